// >>> hdl/lsir_defines.vh
// Constants for the light sensor interrupt and data register block.
// Assumes inclusion by bare name from every design file of the block.
`ifndef LSIR_DEFINES_VH
`define LSIR_DEFINES_VH

// Serial bus device address, seven bits
`define LSIR_DEV_ADDR        7'h44

// Register pointer values
`define LSIR_REG_COMMAND     3'h0
`define LSIR_REG_CTRL        3'h1
`define LSIR_REG_UPPER       3'h2
`define LSIR_REG_LOWER       3'h3
`define LSIR_REG_RES_LO      3'h4
`define LSIR_REG_RES_HI      3'h5
`define LSIR_REG_TMR_LO      3'h6
`define LSIR_REG_TMR_HI      3'h7

// Pointer byte command bits
`define LSIR_PTR_SYNC_BIT    7
`define LSIR_PTR_CLR_BIT     6

// Control register fields
`define LSIR_CTRL_FLAG_BIT   5
`define LSIR_CTRL_RANGE_HI   3
`define LSIR_CTRL_RANGE_LO   2
`define LSIR_CTRL_PERS_HI    1
`define LSIR_CTRL_PERS_LO    0

// Reset values
`define LSIR_CTRL_RST        4'h0
`define LSIR_UPPER_RST       8'hff
`define LSIR_LOWER_RST       8'h00
`define LSIR_LIMIT_LOW_BYTE  8'h00

// Persistence counts in integration cycles
`define LSIR_PERS_0          5'h01
`define LSIR_PERS_1          5'h04
`define LSIR_PERS_2          5'h08
`define LSIR_PERS_3          5'h10

// Range constants in lux
`define LSIR_RANGE_0         18'h007d0
`define LSIR_RANGE_1         18'h01f40
`define LSIR_RANGE_2         18'h07d00
`define LSIR_RANGE_3         18'h1f400

// Result widths per width setting
`define LSIR_NBITS_0         4'hf
`define LSIR_NBITS_1         4'hb
`define LSIR_NBITS_2         4'h7
`define LSIR_NBITS_3         4'h3

`endif

// >>> hdl/lsir_persist.v
// Persistence filter: counts consecutive out-of-window results.
// Assumes sample pulses come from logic on the same clock and reset.
`timescale 1ns/1ns
`default_nettype none
`include "lsir_defines.vh"

module lsir_persist #(
	parameter CW = 5
) (
	input  wire            clk,
	input  wire            rst_n,
	input  wire            sample,
	input  wire            outside,
	input  wire [1:0]      persist_select,
	output reg             fire
);

	reg  [CW-1:0] cnt_q;
	reg  [CW-1:0] target;
	wire [CW-1:0] cnt_inc;

	assign cnt_inc = cnt_q + {{(CW-1){1'b0}}, 1'b1};

	always @* begin
		case (persist_select)
			2'h0: target = `LSIR_PERS_0;
			2'h1: target = `LSIR_PERS_1;
			2'h2: target = `LSIR_PERS_2;
			default: target = `LSIR_PERS_3;
		endcase
	end

	// fire after m consecutive outside results
	// any in-window result restarts the run
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {CW{1'b0}};
			fire  <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (sample) begin
				if (!outside) begin
					cnt_q <= {CW{1'b0}};
				end else if (cnt_inc >= target) begin
					fire  <= 1'b1;
					cnt_q <= {CW{1'b0}};   // Next event needs a fresh run
				end else begin
					cnt_q <= cnt_inc;
				end
			end
		end
	end

endmodule
`default_nettype wire

// >>> hdl/lsir_regs.v
// Serial-bus register file, threshold interrupt and result latches.
// Assumes the converter logic shares clk; scl and sda are open-drain
// pins resolved outside, sampled here through two flip-flops.
`timescale 1ns/1ns
`default_nettype none
`include "lsir_defines.vh"

// Functional notes
// - Flag bit 5 set on interrupt event
// - Writing zero to flag bit clears it
// - Address bit 6 write clears interrupt
// - Bits 3:2 select four lux ranges
// - Interrupt only after m consecutive outside results
// - Bits 1:0 select persistence 1,4,8,16
// - Outside means above upper or below lower
// - Interrupt pin open-drain, active low
// - Threshold byte is limit upper byte
// - Upper threshold resets to ff
// - Lower threshold resets to 00
// - Result registers refresh every integration
// - Result shown as signed 15-bit
// - Result low byte 04, high 05
// - Timer counts clock cycles during integration
// - Timer latched at end, bytes 06/07
// - Timer meaningful only in external timing
// - Internal result width 3,7,11,15 bits
// - Max count 2^n or latched timer
module lsir_regs #(
	parameter TW = 16
) (
	input  wire            clock,
	input  wire            rst_n,
	input  wire            scl_in,
	input  wire            sda_in,
	output wire            sda_out,
	output wire            sda_oe_n,
	output wire            int_out,
	output wire            int_oe_n,
	input  wire            integ_active,
	input  wire            integ_done,
	input  wire [15:0]     conv_data,
	input  wire            ext_timing,
	input  wire [1:0]      width_select,
	output reg             sync_pulse,
	output reg  [1:0]      range_select,
	output reg  [17:0]     full_scale_span,
	output reg  [3:0]      result_bits,
	output reg  [16:0]     max_count,
	output reg             timer_valid
);

	// Bus controller states
	localparam ST_IDLE  = 3'h0;
	localparam ST_ADDR  = 3'h1;
	localparam ST_AACK  = 3'h2;
	localparam ST_PTR   = 3'h3;
	localparam ST_WACK  = 3'h4;
	localparam ST_WDATA = 3'h5;
	localparam ST_RDATA = 3'h6;
	localparam ST_MACK  = 3'h7;

	reg        rst_m_q;
	reg        rst_s_q;
	wire       rst_i_n;

	// Reset release through two flip-flops, assertion stays asynchronous
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_s_q <= rst_m_q;
		end
	end
	assign rst_i_n = rst_s_q;

	reg        scl_m_q;
	reg        scl_s_q;
	reg        scl_p_q;
	reg        sda_m_q;
	reg        sda_s_q;
	reg        sda_p_q;

	// Pin synchronisers; edge history reads only the second stage
	always @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_in;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;

	// Start and stop are sda edges while scl stays high
	assign scl_rise  = scl_s_q & ~scl_p_q;
	assign scl_fall  = ~scl_s_q & scl_p_q;
	assign bus_start = scl_s_q & scl_p_q & ~sda_s_q & sda_p_q;
	assign bus_stop  = scl_s_q & scl_p_q & sda_s_q & ~sda_p_q;

	reg  [2:0] state_q;
	reg  [3:0] bcnt_q;
	reg  [7:0] shift_q;
	reg  [7:0] tx_q;
	reg  [2:0] ptr_q;
	reg        rw_q;
	reg        nack_q;
	reg        drive_q;

	reg        flag_q;
	reg  [3:0] ctrl_q;
	reg  [7:0] upper_q;
	reg  [7:0] lower_q;
	reg  [15:0] result_q;
	reg  [15:0] timer_q;
	reg  [TW-1:0] tcount_q;
	reg        pend_q;
	reg  [15:0] pend_res_q;
	reg  [15:0] pend_tmr_q;

	wire       addr_match;
	wire       wr_strobe;
	wire       ptr_strobe;
	wire       clr_by_bit;
	wire       clr_by_addr;
	wire       fire;
	wire       outside;
	wire       bus_busy;
	wire [15:0] res_signed;
	reg  [7:0] rd_byte;

	assign addr_match = (shift_q[7:1] == `LSIR_DEV_ADDR);
	assign ptr_strobe = scl_fall && (state_q == ST_PTR) && (bcnt_q == 4'h8);
	assign wr_strobe  = scl_fall && (state_q == ST_WDATA) && (bcnt_q == 4'h8);
	assign bus_busy   = (state_q != ST_IDLE);

	// data write of zero to the flag bit
	assign clr_by_bit  = wr_strobe && (ptr_q == `LSIR_REG_CTRL) &&
	                     !shift_q[`LSIR_CTRL_FLAG_BIT];
	// pointer byte with its clear bit set
	assign clr_by_addr = ptr_strobe && shift_q[`LSIR_PTR_CLR_BIT];

	// Read data selection by pointer; command register reads as zero
	always @* begin
		case (ptr_q)
			`LSIR_REG_CTRL:   rd_byte = {2'h0, flag_q, 1'b0, ctrl_q};
			`LSIR_REG_UPPER:  rd_byte = upper_q;
			`LSIR_REG_LOWER:  rd_byte = lower_q;
			`LSIR_REG_RES_LO: rd_byte = result_q[7:0];
			`LSIR_REG_RES_HI: rd_byte = result_q[15:8];
			`LSIR_REG_TMR_LO: rd_byte = timer_q[7:0];
			`LSIR_REG_TMR_HI: rd_byte = timer_q[15:8];
			default:          rd_byte = 8'h00;
		endcase
	end

	// Byte-level bus controller: samples on scl rise, changes on scl fall
	always @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			state_q <= ST_IDLE;
			bcnt_q  <= 4'h0;
			shift_q <= 8'h00;
			tx_q    <= 8'h00;
			ptr_q   <= 3'h0;
			rw_q    <= 1'b0;
			nack_q  <= 1'b0;
			drive_q <= 1'b0;
		end else if (bus_start) begin
			state_q <= ST_ADDR;
			bcnt_q  <= 4'h0;
			drive_q <= 1'b0;
		end else if (bus_stop) begin
			state_q <= ST_IDLE;
			drive_q <= 1'b0;
		end else if (scl_rise) begin
			case (state_q)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					shift_q <= {shift_q[6:0], sda_s_q};
					bcnt_q  <= bcnt_q + 4'h1;
				end
				ST_MACK: nack_q <= sda_s_q;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state_q)
				ST_ADDR: begin
					if (bcnt_q == 4'h8) begin
						if (addr_match) begin
							rw_q    <= shift_q[0];
							drive_q <= 1'b1;
							state_q <= ST_AACK;
						end else begin
							state_q <= ST_IDLE;   // Not ours: wait for next start
						end
					end
				end
				ST_AACK: begin
					bcnt_q <= 4'h0;
					if (rw_q) begin
						tx_q    <= {rd_byte[6:0], 1'b0};
						drive_q <= ~rd_byte[7];
						ptr_q   <= ptr_q + 3'h1;
						bcnt_q  <= 4'h1;
						state_q <= ST_RDATA;
					end else begin
						drive_q <= 1'b0;
						state_q <= ST_PTR;
					end
				end
				ST_PTR: begin
					if (bcnt_q == 4'h8) begin
						ptr_q   <= shift_q[2:0];
						drive_q <= 1'b1;
						state_q <= ST_WACK;
					end
				end
				ST_WDATA: begin
					if (bcnt_q == 4'h8) begin
						ptr_q   <= ptr_q + 3'h1;
						drive_q <= 1'b1;
						state_q <= ST_WACK;
					end
				end
				ST_WACK: begin
					drive_q <= 1'b0;
					bcnt_q  <= 4'h0;
					state_q <= ST_WDATA;
				end
				ST_RDATA: begin
					if (bcnt_q == 4'h8) begin
						drive_q <= 1'b0;   // Release for host acknowledge
						state_q <= ST_MACK;
					end else begin
						drive_q <= ~tx_q[7];
						tx_q    <= {tx_q[6:0], 1'b0};
						bcnt_q  <= bcnt_q + 4'h1;
					end
				end
				ST_MACK: begin
					if (nack_q) begin
						state_q <= ST_IDLE;
					end else begin
						tx_q    <= {rd_byte[6:0], 1'b0};
						drive_q <= ~rd_byte[7];
						ptr_q   <= ptr_q + 3'h1;
						bcnt_q  <= 4'h1;
						state_q <= ST_RDATA;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Open-drain data pin: low level only, enable low while pulling
	assign sda_out  = 1'b0;
	assign sda_oe_n = ~drive_q;

	// Writable control fields and thresholds
	always @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ctrl_q  <= `LSIR_CTRL_RST;
			upper_q <= `LSIR_UPPER_RST;
			lower_q <= `LSIR_LOWER_RST;
		end else if (wr_strobe) begin
			case (ptr_q)
				`LSIR_REG_CTRL:  ctrl_q  <= shift_q[3:0];
				`LSIR_REG_UPPER: upper_q <= shift_q;
				`LSIR_REG_LOWER: lower_q <= shift_q;
				default: ;
			endcase
		end
	end

	// External sync command from pointer bit 7, one cycle wide
	always @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			sync_pulse <= 1'b0;
		end else begin
			sync_pulse <= ptr_strobe && shift_q[`LSIR_PTR_SYNC_BIT];
		end
	end

	// timer counts each clock during integration
	always @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			tcount_q <= {TW{1'b0}};
		end else if (integ_done) begin
			tcount_q <= {TW{1'b0}};
		end else if (integ_active) begin
			tcount_q <= tcount_q + {{(TW-1){1'b0}}, 1'b1};
		end
	end

	// sign of the 15-bit result fills the top bit
	assign res_signed = {conv_data[14], conv_data[14:0]};

	// held while a bus transfer runs, then applied together
	always @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			result_q   <= 16'h0000;
			timer_q    <= 16'h0000;
			pend_q     <= 1'b0;
			pend_res_q <= 16'h0000;
			pend_tmr_q <= 16'h0000;
		end else if (integ_done && bus_busy) begin
			pend_q     <= 1'b1;
			pend_res_q <= res_signed;
			pend_tmr_q <= tcount_q[15:0];
		end else if (integ_done) begin
			pend_q   <= 1'b0;
			result_q <= res_signed;
			timer_q  <= tcount_q[15:0];
		end else if (pend_q && !bus_busy) begin
			pend_q   <= 1'b0;
			result_q <= pend_res_q;
			timer_q  <= pend_tmr_q;
		end
	end

	// outside when above upper or below lower
	// limits are threshold byte over a zero byte
	assign outside =
		($signed({res_signed[15], res_signed}) >
		 $signed({1'b0, upper_q, `LSIR_LIMIT_LOW_BYTE})) ||
		($signed({res_signed[15], res_signed}) <
		 $signed({1'b0, lower_q, `LSIR_LIMIT_LOW_BYTE}));

	lsir_persist #(
		.CW (5)
	) u_persist (
		.clk            (clock),
		.rst_n          (rst_i_n),
		.sample         (integ_done),
		.outside        (outside),
		.persist_select (ctrl_q[`LSIR_CTRL_PERS_HI:`LSIR_CTRL_PERS_LO]),
		.fire           (fire)
	);

	// flag set on event, set wins over a clear in the same cycle
	// held until the host clears it
	always @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			flag_q <= 1'b0;
		end else if (fire) begin
			flag_q <= 1'b1;
		end else if (clr_by_bit || clr_by_addr) begin
			flag_q <= 1'b0;
		end
	end

	// pull the pin low only while pending, never drive high
	assign int_out  = 1'b0;
	assign int_oe_n = ~flag_q;

	// Derived range, width and full-count figures for the lux math
	always @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			range_select    <= 2'h0;
			full_scale_span <= `LSIR_RANGE_0;
			result_bits     <= `LSIR_NBITS_0;
			max_count       <= 17'h08000;
			timer_valid     <= 1'b0;
		end else begin
			range_select <= ctrl_q[`LSIR_CTRL_RANGE_HI:`LSIR_CTRL_RANGE_LO];
			case (ctrl_q[`LSIR_CTRL_RANGE_HI:`LSIR_CTRL_RANGE_LO])
				2'h0: full_scale_span <= `LSIR_RANGE_0;
				2'h1: full_scale_span <= `LSIR_RANGE_1;
				2'h2: full_scale_span <= `LSIR_RANGE_2;
				default: full_scale_span <= `LSIR_RANGE_3;
			endcase
			// result width from the width setting
			case (width_select)
				2'h0: result_bits <= `LSIR_NBITS_0;
				2'h1: result_bits <= `LSIR_NBITS_1;
				2'h2: result_bits <= `LSIR_NBITS_2;
				default: result_bits <= `LSIR_NBITS_3;
			endcase
			// timer only meaningful in external timing
			timer_valid <= ext_timing;
			// full count is 2^n or the latched timer
			if (ext_timing) begin
				max_count <= {1'b0, timer_q};
			end else begin
				case (width_select)
					2'h0: max_count <= 17'h08000;
					2'h1: max_count <= 17'h00800;
					2'h2: max_count <= 17'h00080;
					default: max_count <= 17'h00008;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// >>> sim/light_sensor_irq_and_data_regs_test.sv
// Testbench for the sensor register block over its serial bus.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
`include "lsir_defines.vh"
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin \
	$display("wrong value %s expected %h seen %h", n, e, g); fail_count++; end end
module light_sensor_irq_and_data_regs_test;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        integ_active = 1'b0;
	logic        integ_done = 1'b0;
	logic        ext_timing = 1'b0;
	logic [1:0]  width_select = 2'h0;
	logic [15:0] conv_data = 16'h0000;
	logic [15:0] w;
	wire         scl, sda_rel, sda_out, sda_oe_n, int_out, int_oe_n, sync_pulse, timer_valid;
	wire  [1:0]  range_select;
	wire  [17:0] full_scale_span;
	wire  [3:0]  result_bits;
	wire  [16:0] max_count;
	int          fail_count = 0;
	int          samples_checked = 0;
	logic        sync_seen = 1'b0;
	logic [17:0] spans [4] = '{`LSIR_RANGE_0, `LSIR_RANGE_1, `LSIR_RANGE_2, `LSIR_RANGE_3};
	logic [3:0]  nb [4] = '{4'hf, 4'hb, 4'h7, 4'h3};
	int          pm [4] = '{1, 4, 8, 16};
	// Pulled-up data line: anyone may pull it low
	wire         sda = sda_rel & (sda_oe_n | sda_out);
	always #5 clock = ~clock;
	// Sticky capture, the sync strobe lasts one clock only
	always @(posedge clock) begin
		if (sync_pulse)
			sync_seen <= 1'b1;
	end
	lsir_host_model u_host (.clock(clock), .scl(scl), .sda_rel(sda_rel), .sda(sda));
	lsir_regs #(.TW(16)) u_dut (.clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
		.integ_active(integ_active), .integ_done(integ_done), .conv_data(conv_data),
		.ext_timing(ext_timing), .width_select(width_select), .sync_pulse(sync_pulse),
		.range_select(range_select), .full_scale_span(full_scale_span),
		.result_bits(result_bits), .max_count(max_count), .timer_valid(timer_valid));
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One integration of n clocks ending in a result; leaves three clocks to settle
	task automatic integ(input logic [15:0] d, input int n);
		@(posedge clock) integ_active <= 1'b1;
		repeat (n) @(posedge clock);
		integ_active <= 1'b0;
		integ_done <= 1'b1;
		conv_data <= d;
		@(posedge clock) integ_done <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	// A hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge clock);
		fail_count++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
		u_host.rd2(8'h02, w); `CHK("thresholds", 16'h00ff, w)
		for (int k = 0; k < 4; k++) begin
			u_host.wr(8'h01, 8'(k << 2));
			`CHK("span", spans[k], full_scale_span)
		end
		// Limits 1000h and 0100h, four in a row; equal to the limit is inside
		u_host.wr(8'h02, 8'h10);
		u_host.wr(8'h03, 8'h01);
		u_host.wr(8'h01, 8'h01);
		for (int i = 0; i < 8; i++) begin
			integ((i == 3) ? 16'h1000 : 16'h1001, 8);
			`CHK("pin", (i == 7) ? 1'b0 : 1'b1, int_oe_n)
		end
		u_host.rd2(8'h00, w); `CHK("flag", 8'h21, w[15:8])
		u_host.rd2(8'h06, w); `CHK("timer", 16'h0008, w)
		u_host.rd2(8'h04, w); `CHK("result", 16'h1001, w)
		// Sync-only pointer byte strobes sync and must leave the flag alone
		u_host.clr(8'h81); `CHK("sync", 1'b1, sync_seen)
		`CHK("pin held", 1'b0, int_oe_n)
		u_host.wr(8'h01, 8'h01); `CHK("cleared", 1'b1, int_oe_n)
		// Each persistence code, negative results below the lower limit
		for (int k = 0; k < 4; k++) begin
			u_host.wr(8'h01, 8'(k));
			for (int i = 0; i < pm[k]; i++) begin
				integ(16'h4000, 4);
				`CHK("persist", (i == pm[k] - 1) ? 1'b0 : 1'b1, int_oe_n)
			end
			u_host.clr(8'h41); `CHK("clear cmd", 1'b1, int_oe_n)
		end
		u_host.rd2(8'h04, w); `CHK("signed", 16'hc000, w)
		for (int k = 0; k < 4; k++) begin
			@(posedge clock) width_select <= 2'(k);
			repeat (4) @(posedge clock);
			`CHK("bits", nb[k], result_bits)
			`CHK("max", 17'h1 << nb[k], max_count)
		end
		@(posedge clock) ext_timing <= 1'b1;
		integ(16'h0123, 40);
		`CHK("valid", 1'b1, timer_valid)
		`CHK("ext max", 17'h00028, max_count)
		u_host.rd2(8'h06, w); `CHK("ext timer", 16'h0028, w)
		// A result that lands mid-transfer waits until the bus goes idle
		fork
			u_host.rd2(8'h04, w);
			begin
				repeat (300) @(posedge clock);
				integ(16'h0456, 4);
			end
		join
		`CHK("deferred", 16'h0123, w)
		u_host.rd2(8'h04, w); `CHK("applied", 16'h0456, w)
		u_host.rd2(8'h06, w); `CHK("applied timer", 16'h0004, w)
		test_done();
	end
endmodule
`default_nettype wire

// >>> sim/lsir_host_model.sv
// Serial bus host model driving clock and data toward the block.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none
`include "lsir_defines.vh"
module lsir_host_model (
	input  wire logic clock,
	output var logic  scl,
	output var logic  sda_rel,
	input  wire logic sda
);
	logic ack;
	// Idle bus with both lines released
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// Twenty-clock bit slot; data moves mid-low so it is stable at the rise
	task automatic bitx(input logic b, output logic r);
		repeat (5) @(posedge clock);
		sda_rel <= b;
		repeat (5) @(posedge clock);
		scl <= 1'b1;
		repeat (5) @(posedge clock);
		r = sda;
		repeat (5) @(posedge clock);
		scl <= 1'b0;
	endtask
	// Data rises before the clock so a repeated start never looks like a stop
	task automatic start();
		repeat (5) @(posedge clock);
		sda_rel <= 1'b1;
		repeat (5) @(posedge clock);
		scl <= 1'b1;
		repeat (5) @(posedge clock);
		sda_rel <= 1'b0;
		repeat (5) @(posedge clock);
		scl <= 1'b0;
	endtask
	task automatic stop();
		repeat (5) @(posedge clock);
		sda_rel <= 1'b0;
		repeat (5) @(posedge clock);
		scl <= 1'b1;
		repeat (5) @(posedge clock);
		sda_rel <= 1'b1;
		repeat (5) @(posedge clock);
	endtask
	// One byte out and in, then the acknowledge slot
	task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q);
		logic t;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], t);
			q[i] = t;
		end
		bitx(a, ack);
	endtask
	task automatic wp(input logic [7:0] p);
		logic [7:0] q;
		start();
		xb({`LSIR_DEV_ADDR, 1'b0}, 1'b1, q);
		xb(p, 1'b1, q);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		wp(p);
		xb(d, 1'b1, q);
		stop();
	endtask
	task automatic clr(input logic [7:0] p);
		wp(p);
		stop();
	endtask
	// Pointer set, repeated start, two bytes read low first
	task automatic rd2(input logic [7:0] p, output logic [15:0] w);
		logic [7:0] q;
		wp(p);
		start();
		xb({`LSIR_DEV_ADDR, 1'b1}, 1'b1, q);
		xb(8'hff, 1'b0, w[7:0]);
		xb(8'hff, 1'b1, w[15:8]);
		stop();
	endtask
endmodule
`default_nettype wire

// >>> sim/lsir_regs_sva.sv
// Pin-level checker for the sensor register block.
// Assumes it is bound to lsir_regs and sees only its top ports.
`timescale 1ns/1ns
`default_nettype none
`include "lsir_defines.vh"
module lsir_regs_sva (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        scl_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_n,
	input wire logic        int_out,
	input wire logic        int_oe_n,
	input wire logic        integ_done,
	input wire logic        ext_timing,
	input wire logic [1:0]  width_select,
	input wire logic [1:0]  range_select,
	input wire logic [17:0] full_scale_span,
	input wire logic [3:0]  result_bits,
	input wire logic [16:0] max_count,
	input wire logic        timer_valid
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Open-drain pins only ever pull low
	sda_low_a: assert property (sda_out == 1'b0)
		else $error("data pin drives high");
	int_low_a: assert property (int_out == 1'b0)
		else $error("interrupt pin drives high");
	// Pin falls two clocks after the integration that completes the run
	fire_time_a: assert property ($fell(int_oe_n) |-> $past(integ_done, 2))
		else $error("interrupt without integration end");
	// Release only happens inside a bus transfer, while the clock is low
	hold_a: assert property ($rose(int_oe_n) |-> !scl_in)
		else $error("interrupt released without host clear");
	span_map_a: assert property ($stable(range_select) |-> full_scale_span ==
		(range_select == 2'h0 ? `LSIR_RANGE_0 : range_select == 2'h1 ? `LSIR_RANGE_1 :
		range_select == 2'h2 ? `LSIR_RANGE_2 : `LSIR_RANGE_3))
		else $error("span does not match range");
	bits_map_a: assert property ($stable(width_select)[*3] |-> result_bits ==
		(width_select == 2'h0 ? 4'hf : width_select == 2'h1 ? 4'hb :
		width_select == 2'h2 ? 4'h7 : 4'h3))
		else $error("result width wrong");
	max_int_a: assert property ((!timer_valid && $stable(result_bits))[*3] |->
		max_count == (17'h1 << result_bits))
		else $error("internal max count wrong");
	valid_a: assert property ($stable(ext_timing)[*2] |-> timer_valid == ext_timing)
		else $error("timer valid does not follow mode");
	// Main scenarios reached
	cover property ($fell(int_oe_n));
	cover property ($rose(int_oe_n));
	cover property ($fell(sda_oe_n));
endmodule
bind lsir_regs lsir_regs_sva u_sva (.clock(clock), .rst_n(rst_n), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
	.integ_done(integ_done), .ext_timing(ext_timing), .width_select(width_select),
	.range_select(range_select), .full_scale_span(full_scale_span),
	.result_bits(result_bits), .max_count(max_count), .timer_valid(timer_valid));
`default_nettype wire
